//--- raid_xor_dma_channel.sv
// Purpose: one descriptor-driven copy and parity DMA channel
// Assumes: memory side answers on the same clock; register port at window offsets
// Notes: a buffer parity error on a long descriptor hangs the channel until i_srst
`timescale 1ns/10ps
module raid_xor_dma_channel (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_desc_valid,
  input wire logic [31:0] i_desc_ctrl,
  input wire logic [31:0] i_desc_size,
  input wire logic i_xfer_done,
  input wire logic i_dst_addr_fault,
  input wire logic i_rd_poison,
  input wire logic i_buf_parity_err,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_desc_req,
  output logic [15:0] o_desc_index,
  output logic o_xfer_req,
  output logic [20:0] o_xfer_len,
  output logic o_xfer_xor,
  output logic o_xfer_p_en,
  output logic o_xfer_q_en,
  output logic o_cmpl_wr,
  output logic [31:0] o_cmpl_addr,
  output logic [15:0] o_cmpl_index,
  output logic o_intr
);

  raid_xor_dma_pkg::chan_state_t state_r;
  raid_xor_dma_pkg::chan_state_t state_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] idx_r;
  logic [15:0] idx_nxt;
  logic [31:0] cmpl_addr_r;
  logic [31:0] cmpl_addr_nxt;
  logic suspend_r;
  logic suspend_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic desc_req_r;
  logic desc_req_nxt;
  logic xfer_req_r;
  logic xfer_req_nxt;
  logic [23:0] xfer_info_r;
  logic [23:0] xfer_info_nxt;
  logic cmpl_wr_r;
  logic cmpl_wr_nxt;
  logic [15:0] cmpl_idx_r;
  logic [15:0] cmpl_idx_nxt;
  logic intr_r;
  logic intr_nxt;

  logic cnt_wr;
  logic cmd_wr;
  logic err_w1c;
  logic copy_w1c;
  logic mask_we;
  logic in_xfer;
  logic hang;
  logic [31:0] err_set;
  logic [31:0] err_q;
  logic [31:0] copy_q;
  logic [31:0] mask_q;
  logic halt_req;
  logic [2:0] sts_code;

  logic dec_xor;
  logic dec_null;
  logic dec_intr;
  logic dec_cmpl;
  logic dec_p_en;
  logic dec_q_en;
  logic dec_big;
  logic [20:0] dec_len;

  // ==========================================================================
  // register port decode
  always_comb begin
    cnt_wr = i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::DESC_COUNT_OFS);
    cmd_wr = i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::CHAN_CMD_OFS);
    err_w1c = i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::CHAN_ERR_OFS);
    copy_w1c = i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::ERR_COPY_OFS);
    mask_we = i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::ERR_MASK_OFS);
  end

  // ==========================================================================
  // transfer error events
  always_comb begin
    in_xfer = (state_r == raid_xor_dma_pkg::ST_XFER);
    hang = in_xfer && i_buf_parity_err && dec_big;
    err_set = 32'h0000_0000;
    err_set[raid_xor_dma_pkg::ERR_DST_ADDR_BIT] = in_xfer && i_dst_addr_fault;
    err_set[raid_xor_dma_pkg::ERR_RD_DATA_BIT] = in_xfer &&
      (i_rd_poison || (i_buf_parity_err && !dec_big));
  end

  dma_err_log u_err_log (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_set(err_set),
    .i_err_w1c(err_w1c),
    .i_copy_w1c(copy_w1c),
    .i_mask_we(mask_we),
    .i_wdata(i_reg_wdata),
    .o_err(err_q),
    .o_copy(copy_q),
    .o_mask(mask_q),
    .o_halt_req(halt_req)
  );

  dma_desc_decode u_decode (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_load(i_desc_valid && (state_r == raid_xor_dma_pkg::ST_FETCH)),
    .i_ctrl(i_desc_ctrl),
    .i_size(i_desc_size),
    .o_xor(dec_xor),
    .o_null(dec_null),
    .o_intr(dec_intr),
    .o_cmpl(dec_cmpl),
    .o_p_en(dec_p_en),
    .o_q_en(dec_q_en),
    .o_big(dec_big),
    .o_len(dec_len)
  );

  // ==========================================================================
  // channel sequencer
  always_comb begin
    state_nxt = state_r;
    count_nxt = cnt_wr ? i_reg_wdata[15:0] : count_r;
    idx_nxt = idx_r;
    suspend_nxt = suspend_r;
    desc_req_nxt = 1'b0;
    xfer_req_nxt = 1'b0;
    xfer_info_nxt = xfer_info_r;
    cmpl_wr_nxt = 1'b0;
    cmpl_idx_nxt = cmpl_idx_r;
    intr_nxt = 1'b0;
    if (cmd_wr && i_reg_wdata[raid_xor_dma_pkg::CMD_SUSPEND_BIT]) begin
      suspend_nxt = 1'b1;
    end
    if (cnt_wr) begin
      suspend_nxt = 1'b0;
    end
    case (state_r)
      raid_xor_dma_pkg::ST_IDLE: begin
        if (suspend_r) begin
          state_nxt = raid_xor_dma_pkg::ST_SUSP;
        end else if (idx_r != count_r) begin
          state_nxt = raid_xor_dma_pkg::ST_FETCH;
          desc_req_nxt = 1'b1;
        end
      end
      raid_xor_dma_pkg::ST_FETCH: begin
        if (i_desc_valid) begin
          state_nxt = raid_xor_dma_pkg::ST_EXEC;
        end
      end
      raid_xor_dma_pkg::ST_EXEC: begin
        if (dec_null) begin
          state_nxt = raid_xor_dma_pkg::ST_CMPL;
        end else begin
          state_nxt = raid_xor_dma_pkg::ST_XFER;
          xfer_req_nxt = 1'b1;
          xfer_info_nxt = {dec_xor, dec_p_en, dec_q_en, dec_len};
        end
      end
      raid_xor_dma_pkg::ST_XFER: begin
        if (hang) begin
          state_nxt = raid_xor_dma_pkg::ST_HUNG;
        end else if (halt_req) begin
          state_nxt = raid_xor_dma_pkg::ST_HALT;
        end else if (i_xfer_done || (err_set != 32'h0000_0000)) begin
          state_nxt = raid_xor_dma_pkg::ST_CMPL;
        end
      end
      raid_xor_dma_pkg::ST_CMPL: begin
        intr_nxt = dec_intr;
        cmpl_wr_nxt = dec_cmpl;
        cmpl_idx_nxt = idx_r;
        idx_nxt = idx_r + 16'h0001;
        state_nxt = raid_xor_dma_pkg::ST_IDLE;
      end
      raid_xor_dma_pkg::ST_HALT: begin
        if (cnt_wr && (err_q == 32'h0000_0000)) begin
          state_nxt = raid_xor_dma_pkg::ST_IDLE;
        end
      end
      raid_xor_dma_pkg::ST_SUSP: begin
        if (!suspend_r) begin
          state_nxt = raid_xor_dma_pkg::ST_IDLE;
        end
      end
      raid_xor_dma_pkg::ST_HUNG: begin
        state_nxt = raid_xor_dma_pkg::ST_HUNG;
      end
      default: begin
        state_nxt = raid_xor_dma_pkg::ST_IDLE;
      end
    endcase
    // channel reset drops queued work; a hung channel ignores it
    if (cmd_wr && i_reg_wdata[raid_xor_dma_pkg::CMD_RESET_BIT] &&
        (state_r != raid_xor_dma_pkg::ST_HUNG)) begin
      state_nxt = raid_xor_dma_pkg::ST_IDLE;
      count_nxt = raid_xor_dma_pkg::DESC_COUNT_RST;
      idx_nxt = 16'h0000;
      suspend_nxt = 1'b0;
      desc_req_nxt = 1'b0;
      xfer_req_nxt = 1'b0;
      cmpl_wr_nxt = 1'b0;
      intr_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // register read and completion address
  always_comb begin
    cmpl_addr_nxt = (i_reg_wr && (i_reg_addr == raid_xor_dma_pkg::CMPL_ADDR_OFS)) ?
                    i_reg_wdata : cmpl_addr_r;
    case (state_r)
      raid_xor_dma_pkg::ST_IDLE: sts_code = raid_xor_dma_pkg::STS_IDLE;
      raid_xor_dma_pkg::ST_SUSP: sts_code = raid_xor_dma_pkg::STS_SUSPENDED;
      raid_xor_dma_pkg::ST_HALT: sts_code = raid_xor_dma_pkg::STS_HALTED;
      raid_xor_dma_pkg::ST_HUNG: sts_code = raid_xor_dma_pkg::STS_ACTIVE;
      default: sts_code = raid_xor_dma_pkg::STS_ACTIVE;
    endcase
    rvalid_nxt = i_reg_rd;
    rdata_nxt = 32'h0000_0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        raid_xor_dma_pkg::DESC_COUNT_OFS: rdata_nxt = {16'h0000, count_r};
        raid_xor_dma_pkg::CHAN_STS_OFS: rdata_nxt = {idx_r, 13'h0000, sts_code};
        raid_xor_dma_pkg::CMPL_ADDR_OFS: rdata_nxt = cmpl_addr_r;
        raid_xor_dma_pkg::CHAN_ERR_OFS: rdata_nxt = err_q;
        raid_xor_dma_pkg::ERR_MASK_OFS: rdata_nxt = mask_q;
        raid_xor_dma_pkg::ERR_COPY_OFS: rdata_nxt = copy_q;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= raid_xor_dma_pkg::ST_IDLE;
      count_r <= raid_xor_dma_pkg::DESC_COUNT_RST;
      idx_r <= 16'h0000;
      cmpl_addr_r <= raid_xor_dma_pkg::CMPL_ADDR_RST;
      suspend_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      desc_req_r <= 1'b0;
      xfer_req_r <= 1'b0;
      xfer_info_r <= 24'h00_0000;
      cmpl_wr_r <= 1'b0;
      cmpl_idx_r <= 16'h0000;
      intr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      idx_r <= idx_nxt;
      cmpl_addr_r <= cmpl_addr_nxt;
      suspend_r <= suspend_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      desc_req_r <= desc_req_nxt;
      xfer_req_r <= xfer_req_nxt;
      xfer_info_r <= xfer_info_nxt;
      cmpl_wr_r <= cmpl_wr_nxt;
      cmpl_idx_r <= cmpl_idx_nxt;
      intr_r <= intr_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_desc_req = desc_req_r;
  assign o_desc_index = idx_r;
  assign o_xfer_req = xfer_req_r;
  assign {o_xfer_xor, o_xfer_p_en, o_xfer_q_en, o_xfer_len} = xfer_info_r;
  assign o_cmpl_wr = cmpl_wr_r;
  assign o_cmpl_addr = cmpl_addr_r;
  assign o_cmpl_index = cmpl_idx_r;
  assign o_intr = intr_r;

  // ==========================================================================
  // checks
  AST_NULL_INTR: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state_r == raid_xor_dma_pkg::ST_FETCH) && i_desc_valid && !cmd_wr &&
    (i_desc_ctrl[raid_xor_dma_pkg::OP_MSB:raid_xor_dma_pkg::OP_LSB] < 8'h89) &&
    i_desc_ctrl[raid_xor_dma_pkg::CTRL_NULL_BIT] && i_desc_ctrl[raid_xor_dma_pkg::CTRL_INTR_BIT]
    |-> (!o_xfer_req)[*4] ##0 o_intr)
    else $error("null descriptor moved data or gave no interrupt");

  AST_DST_FAULT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    in_xfer && i_dst_addr_fault && !mask_q[raid_xor_dma_pkg::ERR_DST_ADDR_BIT] && !hang && !cmd_wr
    |=> err_q[raid_xor_dma_pkg::ERR_DST_ADDR_BIT] && copy_q[raid_xor_dma_pkg::ERR_DST_ADDR_BIT] &&
        (state_r == raid_xor_dma_pkg::ST_HALT))
    else $error("destination fault not logged or channel not halted");

  AST_POISON_HALT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    in_xfer && i_rd_poison && !mask_q[raid_xor_dma_pkg::ERR_RD_DATA_BIT] && !hang && !cmd_wr
    |=> err_q[raid_xor_dma_pkg::ERR_RD_DATA_BIT] && (state_r == raid_xor_dma_pkg::ST_HALT))
    else $error("poisoned read not logged or channel not halted");

  AST_COUNT_STARTS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state_r == raid_xor_dma_pkg::ST_IDLE) && !suspend_r && cnt_wr && !cmd_wr &&
    (idx_r == count_r) &&
    (i_reg_wdata[15:0] != idx_r) |-> ##2 (o_desc_req && (o_desc_index == $past(idx_r, 2))))
    else $error("descriptor count write did not start a fetch");

  AST_HUNG_STAYS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    hang |=> (state_r == raid_xor_dma_pkg::ST_HUNG)[*2])
    else $error("hung channel left the hung state");

  AST_XOR_NOTIFY: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state_r == raid_xor_dma_pkg::ST_CMPL) && dec_xor && !cmd_wr
    |=> (o_intr == $past(dec_intr)) && (o_cmpl_wr == $past(dec_cmpl)))
    else $error("xor completion notification mismatch");

  AST_CMD_SUSPEND: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state_r == raid_xor_dma_pkg::ST_IDLE) && cmd_wr && !cnt_wr && (idx_r == count_r) &&
    i_reg_wdata[raid_xor_dma_pkg::CMD_SUSPEND_BIT] && !i_reg_wdata[raid_xor_dma_pkg::CMD_RESET_BIT]
    ##1 !cnt_wr && !cmd_wr |=> (state_r == raid_xor_dma_pkg::ST_SUSP))
    else $error("suspend command not obeyed");

  AST_CMD_RESET: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    cmd_wr && i_reg_wdata[raid_xor_dma_pkg::CMD_RESET_BIT] &&
    (state_r != raid_xor_dma_pkg::ST_HUNG)
    |=> (state_r == raid_xor_dma_pkg::ST_IDLE) && (idx_r == 16'h0000) && (count_r == 16'h0000))
    else $error("reset command not obeyed");

  AST_HALT_HOLDS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state_r == raid_xor_dma_pkg::ST_HALT) && !cnt_wr && !cmd_wr
    |=> (state_r == raid_xor_dma_pkg::ST_HALT) &&
        (((err_q ^ $past(err_q)) & ~$past(i_reg_wdata & {32{err_w1c}})) == 32'h0000_0000))
    else $error("halted channel resumed or lost an error without restart");

endmodule

//--- raid_xor_dma_pkg.sv
// Purpose: shared constants and types of the parity DMA channel
// Assumes: byte offsets within the channel register window
// Notes: field positions are bit indices of the command, error, status and descriptor control words
package raid_xor_dma_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] CHAN_CMD_OFS = 12'h084;
  localparam logic [11:0] DESC_COUNT_OFS = 12'h086;
  localparam logic [11:0] CHAN_STS_OFS = 12'h088;
  localparam logic [11:0] CMPL_ADDR_OFS = 12'h098;
  localparam logic [11:0] CHAN_ERR_OFS = 12'h0A8;
  localparam logic [11:0] ERR_MASK_OFS = 12'h0AC;
  localparam logic [11:0] ERR_COPY_OFS = 12'h180;

  // ==========================================================================
  // reset values
  localparam logic [15:0] DESC_COUNT_RST = 16'h0000;
  localparam logic [31:0] CMPL_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] ERR_RST = 32'h0000_0000;
  localparam logic [31:0] ERR_MASK_RST = 32'h0000_0000;

  // ==========================================================================
  // field positions
  localparam int CMD_SUSPEND_BIT = 2;
  localparam int CMD_RESET_BIT = 5;
  localparam int ERR_DST_ADDR_BIT = 1;
  localparam int ERR_RD_DATA_BIT = 8;
  localparam int CTRL_INTR_BIT = 0;
  localparam int CTRL_CMPL_BIT = 3;
  localparam int CTRL_NULL_BIT = 5;
  localparam int CTRL_P_DIS_BIT = 6;
  localparam int CTRL_Q_DIS_BIT = 7;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 24;
  localparam int STS_IDX_LSB = 16;

  // ==========================================================================
  // operation codes and size limits
  localparam logic [7:0] OP_GF_GEN = 8'h89;
  localparam logic [7:0] OP_GF_VAL = 8'h8A;
  localparam logic [7:0] OP_GF_UPD = 8'h8B;
  localparam logic [20:0] LEN_MAX = 21'h10_0000;
  localparam logic [20:0] LEN_8K = 21'h00_2000;

  // ==========================================================================
  // channel status codes
  localparam logic [2:0] STS_ACTIVE = 3'h0;
  localparam logic [2:0] STS_IDLE = 3'h1;
  localparam logic [2:0] STS_SUSPENDED = 3'h2;
  localparam logic [2:0] STS_HALTED = 3'h3;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_FETCH = 8'h02,
    ST_EXEC = 8'h04,
    ST_XFER = 8'h08,
    ST_CMPL = 8'h10,
    ST_HALT = 8'h20,
    ST_SUSP = 8'h40,
    ST_HUNG = 8'h80
  } chan_state_t;

endpackage

//--- dma_desc_decode.sv
// Purpose: latch and decode one fetched descriptor
// Assumes: i_load is a one-cycle strobe with the descriptor words
// Notes: outputs hold until the next load
`timescale 1ns/10ps
module dma_desc_decode (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [31:0] i_ctrl,
  input wire logic [31:0] i_size,
  output logic o_xor,
  output logic o_null,
  output logic o_intr,
  output logic o_cmpl,
  output logic o_p_en,
  output logic o_q_en,
  output logic o_big,
  output logic [20:0] o_len
);

  logic [7:0] op;
  logic is_xor;
  logic [20:0] len;
  logic [27:0] dec_r;
  logic [27:0] dec_nxt;

  // ==========================================================================
  // decode
  always_comb begin
    op = i_ctrl[raid_xor_dma_pkg::OP_MSB:raid_xor_dma_pkg::OP_LSB];
    is_xor = (op == raid_xor_dma_pkg::OP_GF_GEN) || (op == raid_xor_dma_pkg::OP_GF_VAL) ||
             (op == raid_xor_dma_pkg::OP_GF_UPD);
    // legacy length and xor block size both come from the size word, clipped at 1MB
    len = (i_size > 32'(raid_xor_dma_pkg::LEN_MAX)) ? raid_xor_dma_pkg::LEN_MAX :
          i_size[20:0];
    dec_nxt = dec_r;
    if (i_load) begin
      dec_nxt = {is_xor,
                 ~is_xor & i_ctrl[raid_xor_dma_pkg::CTRL_NULL_BIT],
                 i_ctrl[raid_xor_dma_pkg::CTRL_INTR_BIT],
                 i_ctrl[raid_xor_dma_pkg::CTRL_CMPL_BIT],
                 is_xor & ~i_ctrl[raid_xor_dma_pkg::CTRL_P_DIS_BIT],
                 is_xor & ~i_ctrl[raid_xor_dma_pkg::CTRL_Q_DIS_BIT],
                 len > raid_xor_dma_pkg::LEN_8K,
                 len};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      dec_r <= 28'h000_0000;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  assign {o_xor, o_null, o_intr, o_cmpl, o_p_en, o_q_en, o_big, o_len} = dec_r;

  AST_SIZE_TAKEN: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_load && (i_size <= 32'(raid_xor_dma_pkg::LEN_MAX)) |=> o_len == $past(i_size[20:0]))
    else $error("descriptor size not taken from size field");

endmodule

//--- dma_err_log.sv
// Purpose: channel error, config copy and mask registers
// Assumes: write-one-to-clear strobes come from the register port
// Notes: a set in the clearing cycle wins
`timescale 1ns/10ps
module dma_err_log (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [31:0] i_set,
  input wire logic i_err_w1c,
  input wire logic i_copy_w1c,
  input wire logic i_mask_we,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_err,
  output logic [31:0] o_copy,
  output logic [31:0] o_mask,
  output logic o_halt_req
);

  logic [31:0] err_r;
  logic [31:0] err_nxt;
  logic [31:0] copy_r;
  logic [31:0] copy_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;

  // ==========================================================================
  // per-bit sticky error and copy logic, plain mask write
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_bit
      always_comb begin
        err_nxt[b] = i_set[b] | (err_r[b] & ~(i_err_w1c & i_wdata[b]));
        copy_nxt[b] = i_set[b] | (copy_r[b] & ~(i_copy_w1c & i_wdata[b]));
        mask_nxt[b] = i_mask_we ? i_wdata[b] : mask_r[b];
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      err_r <= raid_xor_dma_pkg::ERR_RST;
      copy_r <= raid_xor_dma_pkg::ERR_RST;
      mask_r <= raid_xor_dma_pkg::ERR_MASK_RST;
    end else begin
      err_r <= err_nxt;
      copy_r <= copy_nxt;
      mask_r <= mask_nxt;
    end
  end

  // masked errors are still logged but never halt
  assign o_halt_req = |(i_set & ~mask_r);
  assign o_err = err_r;
  assign o_copy = copy_r;
  assign o_mask = mask_r;

  AST_MASK_LOGS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_set != 32'h0000_0000) && ((i_set & ~mask_r) == 32'h0000_0000) |->
      !o_halt_req ##1 ((o_err & $past(i_set)) == $past(i_set)))
    else $error("masked error halted or was not logged");

endmodule

//--- dma_mem_model.sv
// Purpose: memory side stand-in for the parity DMA channel
// Assumes: one descriptor and one transfer outstanding at a time
// Notes: i_kind 0 done, 1 dst fault, 2 poison, 3 buffer parity
`timescale 1ns/10ps
module dma_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_desc_req,
  input wire logic i_xfer_req,
  input wire logic [31:0] i_ctrl,
  input wire logic [31:0] i_size,
  input wire logic [1:0] i_kind,
  input wire logic [2:0] i_lag,
  output logic o_desc_valid = 1'h0,
  output logic [31:0] o_ctrl = 32'h0,
  output logic [31:0] o_size = 32'h0,
  output logic o_done = 1'h0,
  output logic [2:0] o_err = 3'h0
);
  // ==========================================================================
  // answers; words show inverse data outside the valid cycle
  always @(posedge i_ref_clk) begin
    if (i_desc_req === 1'h1) begin
      #1;
      o_desc_valid = 1'h1;
      o_ctrl = i_ctrl;
      o_size = i_size;
      @(posedge i_ref_clk);
      #1;
      o_desc_valid = 1'h0;
      o_ctrl = ~i_ctrl;
      o_size = ~i_size;
    end
    if (i_xfer_req === 1'h1) begin
      repeat (i_lag) @(posedge i_ref_clk);
      #1;
      o_done = (i_kind == 2'h0);
      o_err = (i_kind == 2'h0) ? 3'h0 : 3'h1 << (i_kind - 2'h1);
      @(posedge i_ref_clk);
      #1;
      o_done = 1'h0;
      o_err = 3'h0;
    end
  end
endmodule

//--- raid_xor_dma_channel_tb.sv
// Purpose: self-checking bench of the parity DMA channel
// Assumes: stimulus moves 1 ns after the rising edge
// Notes: ends with the channel hung, so it runs last
`timescale 1ns/10ps
module raid_xor_dma_channel_tb;
  logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, ctrl = 32'h0, size = 32'h0, r, s;
  logic [1:0] kind = 2'h0;
  logic [2:0] lag = 3'h1, err;
  logic dv, done, dreq, xreq, xxor, pen, qen, cw, intr, rv;
  logic [31:0] dc, ds, rdata, caddr;
  logic [15:0] didx, cidx, ei = 16'h0;
  logic [20:0] xlen;
  logic [63:0] rq[$], nt;
  logic [24:0] xq[$], xn;
  int n_errors = 0, checks_done = 0, n_intr = 0, n_xfer = 0, seed = 2;
  initial forever #2.5 clk = ~clk;
  raid_xor_dma_channel dut (.i_ref_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_desc_valid(dv), .i_desc_ctrl(dc),
    .i_desc_size(ds), .i_xfer_done(done), .i_dst_addr_fault(err[0]), .i_rd_poison(err[1]),
    .i_buf_parity_err(err[2]), .o_reg_rdata(rdata), .o_reg_rvalid(rv), .o_desc_req(dreq),
    .o_desc_index(didx), .o_xfer_req(xreq), .o_xfer_len(xlen), .o_xfer_xor(xxor),
    .o_xfer_p_en(pen), .o_xfer_q_en(qen), .o_cmpl_wr(cw), .o_cmpl_addr(caddr),
    .o_cmpl_index(cidx), .o_intr(intr));
  dma_mem_model mem (.i_ref_clk(clk), .i_desc_req(dreq), .i_xfer_req(xreq), .i_ctrl(ctrl),
    .i_size(size), .i_kind(kind), .i_lag(lag), .o_desc_valid(dv), .o_ctrl(dc), .o_size(ds),
    .o_done(done), .o_err(err));
  // ==========================================================================
  // checking
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rv === 1'h1) begin
      nt = rq.pop_front();
      cmp(rdata & nt[63:32], nt[31:0]);
    end
    if (xreq === 1'h1) begin
      n_xfer++;
      xn = xq.pop_front();
      cmp({8'h0, xlen, xxor, pen & xn[24], qen & xn[24]}, {8'h0, xn[23:0]});
    end
    if (dreq === 1'h1) cmp(didx, ei);
    if (cw === 1'h1 || intr === 1'h1) cmp({cw, intr, cidx}, {2'h3, ei});
    if (intr === 1'h1) n_intr++;
  end
  // ==========================================================================
  // bus and descriptor tasks
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    @(posedge clk);
    #1;
    wr = 1'h0;
    rd = 1'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back({m, e});
    acc(1'h0, a, 32'h0);
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] z, input logic [1:0] k,
                     input logic w, input logic [15:0] n);
    int n0;
    n0 = n_intr;
    ei = n - 16'h1;
    ctrl = c;
    size = z;
    kind = k;
    lag = 3'(1 + {$random(seed)} % 4);
    acc(1'h1, raid_xor_dma_pkg::DESC_COUNT_OFS, {16'h0, n});
    for (int i = 0; i < (w ? 80 : 20) && n_intr == n0; i++) @(posedge clk);
    #1;
    if (w && n_intr == n0) cmp(32'h0, 32'h1);
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 srst = 1'h0;
    rdc(raid_xor_dma_pkg::DESC_COUNT_OFS, 32'hFFFF_FFFF, 32'h0);
    rdc(raid_xor_dma_pkg::ERR_MASK_OFS, 32'hFFFF_FFFF, 32'h0);
    rdc(12'h0FC, 32'hFFFF_FFFF, 32'h0);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'hFFFF_FFFF, 32'h1);
    r = $random(seed);
    acc(1'h1, raid_xor_dma_pkg::CMPL_ADDR_OFS, r);
    rdc(raid_xor_dma_pkg::CMPL_ADDR_OFS, 32'hFFFF_FFFF, r);
    cmp(caddr, r);
    run(32'h29, 32'h40, 2'h0, 1'h1, 16'h1);
    cmp(n_xfer, 0);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'hFFFF_FFFF, 32'h0001_0001);
    for (int i = 0; i < 6; i++) begin
      xq.push_back({1'h1, raid_xor_dma_pkg::LEN_8K, 1'h1, ~i[0], ~i[1]});
      run({raid_xor_dma_pkg::OP_GF_GEN + 8'(i % 3), 16'h0, i[1], i[0], 6'h09},
          32'(raid_xor_dma_pkg::LEN_8K), 2'h0, 1'h1, 16'(2 * i + 2));
      run(32'h29, 32'h40, 2'h0, 1'h1, 16'(2 * i + 3));
    end
    s = 32'(1 + {$random(seed)} % 32'h10_0000);
    xq.push_back({1'h0, s[20:0], 3'h0});
    run(32'h09, s, 2'h0, 1'h1, 16'hE);
    xq.push_back({1'h0, raid_xor_dma_pkg::LEN_MAX, 3'h0});
    run(32'h09, 32'h0020_0000, 2'h0, 1'h1, 16'hF);
    xq.push_back({1'h1, 21'h40, 3'h7});
    run(32'h8900_0009, 32'h40, 2'h1, 1'h0, 16'h10);
    rdc(raid_xor_dma_pkg::CHAN_ERR_OFS, 32'hFFFF_FFFF, 32'h2);
    rdc(raid_xor_dma_pkg::ERR_COPY_OFS, 32'hFFFF_FFFF, 32'h2);
    acc(1'h1, raid_xor_dma_pkg::DESC_COUNT_OFS, 32'h10);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'h7, 32'(raid_xor_dma_pkg::STS_HALTED));
    acc(1'h1, raid_xor_dma_pkg::CHAN_ERR_OFS, 32'h2);
    acc(1'h1, raid_xor_dma_pkg::ERR_COPY_OFS, 32'h2);
    acc(1'h1, raid_xor_dma_pkg::ERR_MASK_OFS, 32'h100);
    xq.push_back({1'h1, 21'h40, 3'h7});
    run(32'h8900_0009, 32'h40, 2'h2, 1'h1, 16'h10);
    rdc(raid_xor_dma_pkg::CHAN_ERR_OFS, 32'hFFFF_FFFF, 32'h100);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'h7, 32'(raid_xor_dma_pkg::STS_IDLE));
    acc(1'h1, raid_xor_dma_pkg::ERR_MASK_OFS, 32'h0);
    rdc(raid_xor_dma_pkg::CMPL_ADDR_OFS, 32'hFFFF_FFFF, r);
    rdc(raid_xor_dma_pkg::DESC_COUNT_OFS, 32'hFFFF_FFFF, 32'h10);
    acc(1'h1, raid_xor_dma_pkg::CHAN_CMD_OFS, 32'h20);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'hFFFF_FFFF, 32'h1);
    acc(1'h1, raid_xor_dma_pkg::CHAN_CMD_OFS, 32'h4);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'h7, 32'(raid_xor_dma_pkg::STS_SUSPENDED));
    xq.push_back({1'h1, 21'h3000, 3'h7});
    run(32'h8900_0009, 32'h3000, 2'h3, 1'h0, 16'h1);
    rdc(raid_xor_dma_pkg::CHAN_STS_OFS, 32'hFFFF_FFFF, 32'h0);
    stop_test();
  end
endmodule
